/* design/nvsram_host.sv */
// host controller that drives a nonvolatile sram over its async pins
//
// Behaviour
// - prefix then 0x0C63 read starts recall
// - prefix then 0x0FC0 read starts store
// - prefix then 0x0B45 disables auto store
// - prefix then 0x0B46 re-enables auto store
// - command accesses are chip-select-ended reads
// - write strobe high, six reads consecutive
// - setting change needs following store
// - read and write strobe combinations
// - interleaved access aborts sequence
`timescale 1ns/1ps
`default_nettype none
module nvsram_host
    import nvsram_host_pkg::*;
#(
    parameter int RECALL_CYCLES = RECALL_CYC
) (
    // clock and reset
    input  wire logic                                clock_i,
    input  wire logic                                srst_i,
    // user command port
    input  wire logic                                req_valid_i,
    output logic                                     req_ready_o,
    input  wire nvsram_host_pkg::op_t                req_op_i,
    input  wire logic [nvsram_host_pkg::ADDR_W-1:0]  req_addr_i,
    input  wire logic [nvsram_host_pkg::DATA_W-1:0]  req_wdata_i,
    output logic                                     rsp_valid_o,
    output logic [nvsram_host_pkg::DATA_W-1:0]       rsp_rdata_o,
    output logic                                     rsp_error_o,
    // supply status from outside
    input  wire logic                                supply_low_i,
    // memory pins
    output logic [nvsram_host_pkg::ADDR_W-1:0]       address_lines_o,
    output logic                                     chip_select_n_o,
    output logic                                     write_strobe_n_o,
    output logic                                     output_gate_n_o,
    input  wire logic [nvsram_host_pkg::DATA_W-1:0]  data_i,
    output logic [nvsram_host_pkg::DATA_W-1:0]       data_o,
    output logic                                     data_oe_o,
    input  wire logic                                store_busy_n_i
);
    import nvsram_host_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_STROBE, ST_GAP, ST_BUSY, ST_SETTLE} state_t;

    state_t              state_r;
    op_t                 op_r;
    logic [2:0]          step_r;
    logic [ADDR_W-1:0]   addr_r;
    logic [DATA_W-1:0]   wdata_r;
    logic [DATA_W-1:0]   rdata_r;
    logic                rsp_r;
    logic                err_r;
    logic                busy_s1_r;
    logic                busy_s2_r;
    logic                low_s1_r;
    logic                low_s2_r;
    logic                auto_en_r;
    logic [DATA_W-1:0]   data_s1_r;
    logic [DATA_W-1:0]   data_s2_r;
    logic                tmr_load;
    logic [CNT_W-1:0]    tmr_count;
    logic                tmr_done;

    // pin inputs pass two flops before use
    always_ff @(posedge clock_i) begin
        busy_s1_r <= store_busy_n_i;
        busy_s2_r <= busy_s1_r;
        low_s1_r  <= supply_low_i;
        low_s2_r  <= low_s1_r;
        data_s1_r <= data_i;
        data_s2_r <= data_s1_r;
    end

    // command key for the current step; fixed prefix then the op code
    wire [KEY_W-1:0] cmd_key =
        (op_r == OP_RECALL)   ? CMD_RECALL :
        (op_r == OP_STORE)    ? CMD_STORE :
        (op_r == OP_AUTO_OFF) ? CMD_AUTO_OFF :
        CMD_AUTO_ON;
    wire [KEY_W-1:0] step_key =
        (step_r == 3'd0) ? SEQ_A0 :
        (step_r == 3'd1) ? SEQ_A1 :
        (step_r == 3'd2) ? SEQ_A2 :
        (step_r == 3'd3) ? SEQ_A3 :
        (step_r == 3'd4) ? SEQ_A4 : cmd_key;
    // top address bit is don't-care to the device; drive it low
    wire [ADDR_W-1:0] seq_addr = {1'b0, step_key};
    wire is_cmd   = (op_r != OP_READ) && (op_r != OP_WRITE);
    wire is_write = (op_r == OP_WRITE);
    wire last_step = (step_r == 3'd5);
    wire nv_op    = (op_r == OP_STORE) || (op_r == OP_RECALL);
    // store and write refused while supply is low
    wire blocked  = low_s2_r && ((req_op_i == OP_WRITE) || (req_op_i == OP_STORE));
    wire bus_free = busy_s2_r;
    wire accept   = (state_r == ST_IDLE) && req_valid_i && bus_free;
    wire strobe   = (state_r == ST_STROBE);

    // sequence steps are issued back to back with no other access between
    assign req_ready_o = (state_r == ST_IDLE) && bus_free;

    // timer: strobe width, recall wait, post-busy settle
    assign tmr_load  = (accept && !blocked) || ((state_r == ST_GAP) && tmr_done)
                     || ((state_r == ST_STROBE) && tmr_done)
                     || ((state_r == ST_BUSY) && busy_s2_r);
    assign tmr_count = (state_r == ST_BUSY) ?
                           ((op_r == OP_RECALL) ? CNT_W'(RECALL_CYCLES)
                                                : CNT_W'(POST_STORE_CYC))
                     : CNT_W'(STROBE_CYC);

    nvsram_cycle_timer #(.W(CNT_W)) u_timer (
        .clock_i (clock_i),
        .srst_i  (srst_i),
        .load_i  (tmr_load),
        .count_i (tmr_count),
        .done_o  (tmr_done)
    );

    // main sequencer
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            state_r   <= ST_IDLE;
            op_r      <= OP_READ;
            step_r    <= 3'd0;
            addr_r    <= '0;
            wdata_r   <= DATA_ZERO;
            rdata_r   <= DATA_ZERO;
            rsp_r     <= 1'b0;
            err_r     <= 1'b0;
            auto_en_r <= 1'b1;
        end else begin
            rsp_r <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    if (accept) begin
                        op_r    <= req_op_i;
                        addr_r  <= req_addr_i;
                        wdata_r <= req_wdata_i;
                        step_r  <= 3'd0;
                        if (blocked) begin
                            rsp_r <= 1'b1;
                            err_r <= 1'b1;
                        end else begin
                            state_r <= ST_STROBE;
                        end
                    end
                end
                ST_STROBE: begin
                    if (tmr_done) begin
                        // sixth command read yields no data
                        if (!is_cmd || !last_step) begin
                            rdata_r <= data_s2_r;
                        end
                        state_r <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (tmr_done) begin
                        if (is_cmd && !last_step) begin
                            step_r  <= step_r + 3'd1;
                            state_r <= ST_STROBE;
                        end else if (nv_op) begin
                            state_r <= ST_BUSY;
                        end else begin
                            // setting held only until a store saves it
                            if (op_r == OP_AUTO_OFF) auto_en_r <= 1'b0;
                            if (op_r == OP_AUTO_ON) auto_en_r <= 1'b1;
                            rsp_r   <= 1'b1;
                            err_r   <= 1'b0;
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_BUSY: begin
                    // device busy line low during a store; wait for release
                    if (busy_s2_r) begin
                        state_r <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (tmr_done) begin
                        rsp_r   <= 1'b1;
                        err_r   <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // pins: reads end by chip select, write strobe held high for commands
    assign address_lines_o  = is_cmd ? seq_addr : addr_r;
    assign chip_select_n_o  = !strobe;
    assign write_strobe_n_o = !(strobe && is_write);
    assign output_gate_n_o  = !(strobe && !is_write);
    assign data_o           = wdata_r;
    assign data_oe_o        = strobe && is_write;
    assign rsp_valid_o      = rsp_r;
    assign rsp_rdata_o      = rdata_r;
    assign rsp_error_o      = err_r;
endmodule // nvsram_host
`default_nettype wire

/* design/nvsram_host_pkg.sv */
// constants shared by the nonvolatile sram command host
package nvsram_host_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int KEY_W  = 14;
    localparam logic [KEY_W-1:0] SEQ_A0 = 14'h0E38;
    localparam logic [KEY_W-1:0] SEQ_A1 = 14'h31C7;
    localparam logic [KEY_W-1:0] SEQ_A2 = 14'h03E0;
    localparam logic [KEY_W-1:0] SEQ_A3 = 14'h3C1F;
    localparam logic [KEY_W-1:0] SEQ_A4 = 14'h303F;
    localparam logic [KEY_W-1:0] CMD_RECALL   = 14'h0C63;
    localparam logic [KEY_W-1:0] CMD_STORE    = 14'h0FC0;
    localparam logic [KEY_W-1:0] CMD_AUTO_OFF = 14'h0B45;
    localparam logic [KEY_W-1:0] CMD_AUTO_ON  = 14'h0B46;
    localparam logic [DATA_W-1:0] DATA_ZERO   = 8'h00;
    // bus timing in ns at a 5 ns clock
    localparam int CLK_NS          = 5;
    localparam int STROBE_NS       = 50;
    localparam int RECALL_NS       = 200000;
    localparam int POST_STORE_NS   = 20;
    localparam int STROBE_CYC      = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECALL_CYC      = (RECALL_NS + CLK_NS - 1) / CLK_NS;
    localparam int POST_STORE_CYC  = (POST_STORE_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 24;
    // host commands
    typedef enum logic [2:0] {
        OP_READ, OP_WRITE, OP_STORE, OP_RECALL, OP_AUTO_OFF, OP_AUTO_ON
    } op_t;
endpackage

/* design/nvsram_cycle_timer.sv */
// down counter that pulses done when a loaded wait expires
`timescale 1ns/1ps
`default_nettype none
module nvsram_cycle_timer #(
    parameter int W = 24
) (
    // clock and reset
    input  wire logic         clock_i,
    input  wire logic         srst_i,
    // load and status
    input  wire logic         load_i,
    input  wire logic [W-1:0] count_i,
    output logic              done_o
);
    logic [W-1:0] cnt_r;
    logic         run_r;
    wire          last = run_r && (cnt_r <= {{(W-1){1'b0}}, 1'b1});
    // count down; done is one cycle at the end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            cnt_r <= '0;
            run_r <= 1'b0;
        end else if (load_i) begin
            cnt_r <= count_i;
            run_r <= 1'b1;
        end else if (run_r) begin
            cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
            run_r <= !last;
        end
    end
    // done is not gated by load: the parent reloads on done, so gating would form a loop
    assign done_o = last;
endmodule // nvsram_cycle_timer
`default_nettype wire

/* sim/nvsram_host_sva.sv */
// pin-level assertions for the nonvolatile sram host
`timescale 1ns/1ps
`default_nettype none
module nvsram_host_sva (
    // clock, reset, status
    input wire logic        clock_i, srst_i, req_ready_o, rsp_valid_o, rsp_error_o, supply_low_i,
    // memory pins
    input wire logic [14:0] address_lines_o,
    input wire logic        chip_select_n_o, write_strobe_n_o, output_gate_n_o,
    input wire logic        data_oe_o, store_busy_n_i
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);
    // busy seen long enough to have crossed the two-flop sync
    sequence s_busy_held; !store_busy_n_i [*3]; endsequence
    sequence s_strobe_open; $fell(chip_select_n_o); endsequence
    AST_GATE_EXCL: assert property (!output_gate_n_o |-> write_strobe_n_o)
        else $error("gate and write strobe low together");
    AST_WR_DRIVES: assert property (!write_strobe_n_o |-> !chip_select_n_o && data_oe_o)
        else $error("write strobe without select or data");
    AST_IDLE_QUIET: assert property (chip_select_n_o |-> write_strobe_n_o && output_gate_n_o)
        else $error("strobe active while deselected");
    AST_STROBE_WIDTH: assert property (s_strobe_open |-> !chip_select_n_o [*8])
        else $error("select strobe too short");
    AST_ADDR_HOLD: assert property (!chip_select_n_o && !$past(chip_select_n_o) |-> $stable(address_lines_o))
        else $error("address moved inside strobe");
    AST_BUSY_HALT: assert property (s_busy_held |-> chip_select_n_o && !req_ready_o)
        else $error("access while store busy");
    AST_POST_STORE: assert property ($rose(store_busy_n_i) |-> chip_select_n_o [*4])
        else $error("access too soon after busy release");
    // the host judges supply through its two-flop sync, so look three samples back
    AST_LOW_NO_WRITE: assert property ($fell(write_strobe_n_o) |-> !$past(supply_low_i, 3))
        else $error("write started at low supply");
    AST_REFUSE_QUIET: assert property (rsp_valid_o && rsp_error_o |-> $past(chip_select_n_o) && $past(chip_select_n_o, 2))
        else $error("refused op moved the pins");
endmodule // nvsram_host_sva
bind nvsram_host nvsram_host_sva chk_u (.clock_i(clock_i), .srst_i(srst_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_error_o(rsp_error_o), .supply_low_i(supply_low_i),
    .address_lines_o(address_lines_o), .chip_select_n_o(chip_select_n_o),
    .write_strobe_n_o(write_strobe_n_o), .output_gate_n_o(output_gate_n_o),
    .data_oe_o(data_oe_o), .store_busy_n_i(store_busy_n_i));
`default_nettype wire

/* sim/nvsram_device_model.sv */
// behavioural nonvolatile sram as seen at its pins
`timescale 1ns/1ps
`default_nettype none
module nvsram_device_model
    import nvsram_host_pkg::*;
#(parameter int STORE_NS = 300, parameter int RECALL_NS = 100, parameter int POST_NS = 20) (
    input  wire logic [14:0] address_lines_i,
    input  wire logic        chip_select_n_i, write_strobe_n_i, output_gate_n_i, supply_low_i,
    input  wire logic [7:0]  data_i,
    output logic      [7:0]  data_o,
    output logic             store_busy_n_o, auto_store_o
);
    localparam logic [13:0] PREFIX [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    logic [7:0] sram [32768];
    logic [7:0] nv [32768];
    logic hold = 1'b0, is_wr, is_rd;
    logic [14:0] a;
    logic [7:0] wd;
    int step = 0;
    wire [13:0] key = address_lines_i[13:0];
    wire sixth = step == 5 && (key == CMD_STORE || key == CMD_RECALL);
    wire rd_on = !chip_select_n_i && !output_gate_n_i && write_strobe_n_i && store_busy_n_o && !hold;
    // a released bus shows the inverse, so stale data never passes for a read
    assign data_o = (rd_on && !sixth) ? sram[address_lines_i] : ~sram[address_lines_i];
    initial begin
        foreach (sram[i]) sram[i] = DATA_ZERO;
        foreach (nv[i]) nv[i] = DATA_ZERO;
        store_busy_n_o = 1'b1;
        auto_store_o = 1'b1;
    end
    // mode is taken just after select falls, once the strobes have settled
    always @(negedge chip_select_n_i) begin
        #1;
        a = address_lines_i;
        is_wr = !write_strobe_n_i;
        is_rd = !output_gate_n_i && !is_wr;
        wd = data_i;
    end
    // accesses that end inside a delay below are lost, which is the refusal
    always @(posedge chip_select_n_i) begin
        if (is_wr) begin
            step = 0;
            if (store_busy_n_o && !hold && !supply_low_i) sram[a] = wd;
        end else if (is_rd && step < 5) begin
            step = (a[13:0] == PREFIX[step]) ? step + 1 : int'(a[13:0] == SEQ_A0);
        end else if (is_rd) begin
            step = 0;
            case (a[13:0])
                CMD_STORE: if (!supply_low_i) begin
                    store_busy_n_o = 1'b0;
                    foreach (nv[i]) nv[i] = sram[i];
                    #(STORE_NS);
                    store_busy_n_o = 1'b1;
                    hold = 1'b1;
                    #(POST_NS);
                    hold = 1'b0;
                end
                CMD_RECALL: begin
                    hold = 1'b1;
                    foreach (sram[i]) sram[i] = DATA_ZERO;
                    foreach (sram[i]) sram[i] = nv[i];
                    #(RECALL_NS);
                    hold = 1'b0;
                end
                CMD_AUTO_OFF: auto_store_o = 1'b0;
                CMD_AUTO_ON: auto_store_o = 1'b1;
                default: step = int'(a[13:0] == SEQ_A0);
            endcase
        end
    end
endmodule // nvsram_device_model
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the nonvolatile sram host
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import nvsram_host_pkg::*;
    logic clock_i = 0, srst_i = 1, req_valid_i = 0, supply_low_i = 0, got_e;
    op_t req_op_i = OP_READ;
    logic [14:0] req_addr_i = '0;
    logic [7:0] req_wdata_i = '0, got_d, bus, dut_d, mod_d, rdata;
    wire [14:0] addr_l;
    wire ready, rsp_v, rsp_e, cs_n, we_n, oe_n, d_oe, busy_n, auto_on;
    int n_fail = 0, compares = 0;
    // the host's enable decides who owns the shared data pins
    assign bus = d_oe ? dut_d : mod_d;
    nvsram_host #(.RECALL_CYCLES(20)) dut_u (.clock_i(clock_i), .srst_i(srst_i),
        .req_valid_i(req_valid_i), .req_ready_o(ready), .req_op_i(req_op_i),
        .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_v),
        .rsp_rdata_o(rdata), .rsp_error_o(rsp_e), .supply_low_i(supply_low_i),
        .address_lines_o(addr_l), .chip_select_n_o(cs_n), .write_strobe_n_o(we_n),
        .output_gate_n_o(oe_n), .data_i(bus), .data_o(dut_d), .data_oe_o(d_oe),
        .store_busy_n_i(busy_n));
    nvsram_device_model mod_u (.address_lines_i(addr_l), .chip_select_n_i(cs_n),
        .write_strobe_n_i(we_n), .output_gate_n_i(oe_n), .supply_low_i(supply_low_i),
        .data_i(bus), .data_o(mod_d), .store_busy_n_o(busy_n), .auto_store_o(auto_on));
    initial forever #2.5 clock_i = ~clock_i;
    task automatic final_report();
        $display("counts: %0d compares, %0d mismatches", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    // one request, held until taken, then wait for its answer
    task automatic op(input op_t o, input logic [14:0] a, input logic [7:0] d);
        int i;
        int j;
        req_op_i <= o;
        req_addr_i <= a;
        req_wdata_i <= d;
        req_valid_i <= 1'b1;
        // ready read at the edge shows what the host sampled there; drop valid at once
        for (i = 0; i < 4000; i++) begin
            @(posedge clock_i);
            if (ready === 1'b1) break;
        end
        req_valid_i <= 1'b0;
        for (j = 0; j < 4000; j++) begin
            @(posedge clock_i);
            if (rsp_v === 1'b1) break;
        end
        got_d = rdata;
        got_e = rsp_e;
        if (i == 4000 || j == 4000) begin
            n_fail++;
            $display("wrong value at %0t: no handshake", $time);
            final_report();
        end
    endtask
    task automatic t_start();
        chk1(cs_n, 1'b1);
        chk1(auto_on, 1'b1);
        op(OP_READ, 15'h7FFF, 8'h00);
        chk8(got_d, 8'h00);
        $display("test start done");
    endtask
    task automatic t_rw();
        op(OP_WRITE, 15'h1234, 8'h5A);
        op(OP_WRITE, 15'h1235, 8'hC3);
        op(OP_READ, 15'h1234, 8'h00);
        chk8(got_d, 8'h5A);
        op(OP_READ, 15'h1235, 8'h00);
        chk8(got_d, 8'hC3);
        $display("test read write done");
    endtask
    task automatic t_store_recall();
        op(OP_WRITE, 15'h0100, 8'h77);
        op(OP_STORE, 15'h0000, 8'h00);
        chk1(got_e, 1'b0);
        chk8(mod_u.nv[15'h0100], 8'h77);
        op(OP_WRITE, 15'h0100, 8'h11);
        op(OP_RECALL, 15'h0000, 8'h00);
        op(OP_READ, 15'h0100, 8'h00);
        chk8(got_d, 8'h77);
        chk8(mod_u.nv[15'h0100], 8'h77);
        $display("test store recall done");
    endtask
    task automatic t_auto();
        op(OP_AUTO_OFF, 15'h0000, 8'h00);
        chk1(auto_on, 1'b0);
        op(OP_AUTO_ON, 15'h0000, 8'h00);
        chk1(auto_on, 1'b1);
        op(OP_STORE, 15'h0000, 8'h00);
        chk1(got_e, 1'b0);
        $display("test auto store done");
    endtask
    task automatic t_low();
        supply_low_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        op(OP_WRITE, 15'h0200, 8'h99);
        chk1(got_e, 1'b1);
        op(OP_STORE, 15'h0000, 8'h00);
        chk1(got_e, 1'b1);
        op(OP_READ, 15'h0200, 8'h00);
        chk8(got_d, 8'h00);
        supply_low_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        $display("test low supply done");
    endtask
    initial begin
        repeat (16) @(posedge clock_i);
        srst_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        t_start();
        t_rw();
        t_store_recall();
        t_auto();
        t_low();
        final_report();
    end
endmodule // tb_top
`default_nettype wire
